//--- src/test_mode_pkg.sv
package test_mode_pkg;
   // Register byte offsets
   localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] IN_FORCE_OFS = 32'h0000_0004;
   localparam logic [31:0] OUT_FORCE_OFS = 32'h0000_0008;
   localparam logic [31:0] STATUS_OFS = 32'h0000_000C;
   localparam logic [31:0] CH1_DELAY_OFS = 32'h0000_0010;
   localparam logic [31:0] CH2_DELAY_OFS = 32'h0000_0014;
   localparam logic [31:0] IO_STATE_OFS = 32'h0000_0018;
   // Control field positions
   localparam int CTRL_TEST_EN_BIT = 0;
   localparam int CTRL_ORIG_LSB = 1;
   localparam int CTRL_REP_LSB = 3;
   // Status field positions
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_RES_LSB = 1;
   localparam int STAT_TIMER_BIT = 5;
   localparam int IO_OUT_LSB = 16;
   // Forcing codes
   localparam logic [1:0] IN_DISABLED = 2'h0;
   localparam logic [1:0] IN_OPEN = 2'h1;
   localparam logic [1:0] IN_CLOSED = 2'h2;
   localparam logic [1:0] OUT_DISABLED = 2'h0;
   localparam logic [1:0] OUT_ENERGIZED = 2'h1;
   localparam logic [1:0] OUT_DEENERGIZED = 2'h2;
   localparam logic [1:0] OUT_FREEZE = 2'h3;
   // Loopback results
   localparam logic [1:0] RES_NOT_ACTIVE = 2'h0;
   localparam logic [1:0] RES_OK = 2'h1;
   localparam logic [1:0] RES_FAIL = 2'h2;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing
   localparam longint CLK_PERIOD_NS = 10;
   localparam longint TEST_TIMEOUT_MIN = 20;
   localparam longint TEST_TIMEOUT_CYCLES = TEST_TIMEOUT_MIN * 60 * 1000000000 / CLK_PERIOD_NS;
   localparam longint REPLY_WAIT_NS = 1000000;
   localparam longint REPLY_WAIT_CYCLES = REPLY_WAIT_NS / CLK_PERIOD_NS;
   localparam longint RETEST_NS = 10000000;
   localparam longint RETEST_CYCLES = RETEST_NS / CLK_PERIOD_NS;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // Channel originate sequencer, Gray along idle-send-wait-hold
   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_SEND = 2'b01,
      CH_WAIT = 2'b11,
      CH_HOLD = 2'b10
   } ch_state_e;
endpackage

//--- src/test_mode_channel_tester.sv
module test_mode_channel_tester
   import test_mode_pkg::*;
#(
   parameter int NUM_IN = 8,
   parameter int NUM_OUT = 8,
   parameter longint TIMEOUT_CYCLES = TEST_TIMEOUT_CYCLES,
   parameter longint REPLY_CYCLES = REPLY_WAIT_CYCLES,
   parameter longint PERIOD_CYCLES = RETEST_CYCLES
) (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic [31:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [31:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [NUM_IN-1:0] contact_sense_in,
   input wire logic [NUM_OUT-1:0] contact_drive_in,
   output logic [NUM_IN-1:0] contact_in_out,
   output logic [NUM_OUT-1:0] contact_out_out,
   output logic test_led_out,
   input wire logic [1:0] ch_test_rx_in,
   output logic [1:0] ch_test_tx_out
);
   localparam int NCH = 2;
   localparam int TW = 40;

   // Refuse sizes the register map cannot hold
   if (NUM_IN < 1 || NUM_IN > 16 || NUM_OUT < 1 || NUM_OUT > 16) begin : g_size_chk
      $error("NUM_IN and NUM_OUT must be 1 to 16");
   end
   if (TIMEOUT_CYCLES < 1 || REPLY_CYCLES < 1 || PERIOD_CYCLES <= REPLY_CYCLES) begin : g_time_chk
      $error("Timing parameters out of range");
   end
   // The timeout counter is TW bits wide
   if (TIMEOUT_CYCLES > (64'sh1 <<< TW)) begin : g_timer_chk
      $error("TIMEOUT_CYCLES exceeds the timeout counter");
   end
   // Reply and retest spans share one 32-bit counter per channel
   if (PERIOD_CYCLES > 64'sh1_0000_0000) begin : g_count_chk
      $error("PERIOD_CYCLES exceeds the channel counter");
   end

   // Last count of each timer
   localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT_CYCLES - 1);
   localparam logic [31:0] REPLY_LAST = 32'(REPLY_CYCLES - 1);
   localparam logic [31:0] PERIOD_LAST = 32'(PERIOD_CYCLES - 1);

   typedef struct packed {
      // Settings written over the bus and the timeout timer
      logic test_en;
      logic [NCH-1:0] orig;
      logic [NCH-1:0] rep;
      logic [2*NCH-1:0] mode_prev;
      logic [TW-1:0] timer;
      logic timer_run;
      // Forcing codes, freeze latch and effective contacts
      logic [2*NUM_IN-1:0] in_force;
      logic [2*NUM_OUT-1:0] out_force;
      logic [NUM_OUT-1:0] frozen;
      logic [NUM_IN-1:0] cin;
      logic [NUM_OUT-1:0] cout;
      logic led;
      // Channel testers
      ch_state_e [NCH-1:0] st;
      logic [NCH-1:0][31:0] cnt;
      logic [NCH-1:0][1:0] res;
      logic [NCH-1:0][31:0] delay;
      logic [NCH-1:0] tx;
      // Bus handshake state
      logic aw_held;
      logic w_held;
      logic [31:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic awrdy;
      logic wrdy;
      logic arrdy;
   } state_s;

   state_s s_reg;
   state_s s_next;

   // Byte-lane mask from write strobes
   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         m[8*b +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction

   // Readback of one register word
   function automatic logic [32:0] read_word(input state_s s, input logic [31:0] addr);
      logic [31:0] d;
      logic hit;
      d = 32'h0000_0000;
      hit = 1'b1;
      case (addr)
         CTRL_OFS: begin
            d[CTRL_TEST_EN_BIT] = s.test_en;
            d[CTRL_ORIG_LSB +: NCH] = s.orig;
            d[CTRL_REP_LSB +: NCH] = s.rep;
         end
         IN_FORCE_OFS: d[2*NUM_IN-1:0] = s.in_force;
         OUT_FORCE_OFS: d[2*NUM_OUT-1:0] = s.out_force;
         STATUS_OFS: begin
            d[STAT_ACTIVE_BIT] = s.led;
            d[STAT_RES_LSB +: 2*NCH] = s.res;
            d[STAT_TIMER_BIT] = s.timer_run;
         end
         CH1_DELAY_OFS: d = s.delay[0];
         CH2_DELAY_OFS: d = s.delay[1];
         IO_STATE_OFS: begin
            d[NUM_IN-1:0] = s.cin;
            d[IO_OUT_LSB +: NUM_OUT] = s.cout;
         end
         // Unmapped offsets read zero and answer with an error
         default: hit = 1'b0;
      endcase
      return {hit, d};
   endfunction

   // Next-state logic for bus, forcing, channels and timer
   always_comb begin
      logic [31:0] m;
      logic [32:0] rd;
      logic wr_hit;
      logic any_in;
      logic any_out;
      logic active;
      logic [2*NCH-1:0] mode_now;
      logic [1:0] code;
      m = 32'h0000_0000;
      rd = 33'h0_0000_0000;
      wr_hit = 1'b0;
      any_in = 1'b0;
      any_out = 1'b0;
      active = 1'b0;
      mode_now = '0;
      code = 2'h0;
      s_next = s_reg;

      // Write address and data are taken in either order
      if (s_axi_awvalid_in && s_reg.awrdy) begin
         s_next.aw_held = 1'b1;
         s_next.awaddr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_reg.wrdy) begin
         s_next.w_held = 1'b1;
         s_next.wdata = s_axi_wdata_in;
         s_next.wstrb = s_axi_wstrb_in;
      end

      // Perform the write once both halves are held
      if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
         m = strb_mask(s_reg.wstrb);
         wr_hit = 1'b1;
         case (s_reg.awaddr)
            CTRL_OFS: begin
               if (m[CTRL_TEST_EN_BIT]) begin
                  s_next.test_en = s_reg.wdata[CTRL_TEST_EN_BIT];
               end
               for (int c = 0; c < NCH; c++) begin
                  if (m[CTRL_ORIG_LSB + c]) begin
                     s_next.orig[c] = s_reg.wdata[CTRL_ORIG_LSB + c];
                  end
                  if (m[CTRL_REP_LSB + c]) begin
                     s_next.rep[c] = s_reg.wdata[CTRL_REP_LSB + c];
                  end
               end
            end
            IN_FORCE_OFS: s_next.in_force = (s_reg.in_force & ~m[2*NUM_IN-1:0]) |
                                            (s_reg.wdata[2*NUM_IN-1:0] & m[2*NUM_IN-1:0]);
            OUT_FORCE_OFS: s_next.out_force = (s_reg.out_force & ~m[2*NUM_OUT-1:0]) |
                                              (s_reg.wdata[2*NUM_OUT-1:0] & m[2*NUM_OUT-1:0]);
            CH1_DELAY_OFS, CH2_DELAY_OFS, STATUS_OFS, IO_STATE_OFS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
         endcase
         s_next.aw_held = 1'b0;
         s_next.w_held = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_reg.bvalid && s_axi_bready_in) begin
         s_next.bvalid = 1'b0;
      end

      // Read channel, answer one cycle after the address is taken
      if (s_axi_arvalid_in && s_reg.arrdy) begin
         rd = read_word(s_reg, s_axi_araddr_in);
         s_next.rvalid = 1'b1;
         s_next.rdata = rd[31:0];
         s_next.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      end else if (s_reg.rvalid && s_axi_rready_in) begin
         s_next.rvalid = 1'b0;
      end

      // Timeout: restart on any new turn-on, clear originate and repeat bits at expiry
      mode_now = {s_next.rep, s_next.orig};
      s_next.mode_prev = mode_now;
      if (|(mode_now & ~s_reg.mode_prev)) begin
         s_next.timer = '0;
         s_next.timer_run = 1'b1;
      end else if (!(|mode_now)) begin
         s_next.timer = '0;
         s_next.timer_run = 1'b0;
      end else if (s_reg.timer == TIMEOUT_LAST) begin
         s_next.orig = '0;
         s_next.rep = '0;
         s_next.mode_prev = '0;
         s_next.timer = '0;
         s_next.timer_run = 1'b0;
      end else begin
         s_next.timer = s_reg.timer + TW'(1);
      end

      // Test mode is on while enabled or any forcing is set
      for (int i = 0; i < NUM_IN; i++) begin
         any_in = any_in | (s_next.in_force[2*i +: 2] != IN_DISABLED);
      end
      for (int i = 0; i < NUM_OUT; i++) begin
         any_out = any_out | (s_next.out_force[2*i +: 2] != OUT_DISABLED);
      end
      active = s_next.test_en | any_in | any_out;
      s_next.led = active;

      // Contact inputs: forced value replaces sensed value
      for (int i = 0; i < NUM_IN; i++) begin
         code = s_next.in_force[2*i +: 2];
         case (code)
            IN_OPEN: s_next.cin[i] = 1'b0;
            IN_CLOSED: s_next.cin[i] = 1'b1;
            default: s_next.cin[i] = contact_sense_in[i];
         endcase
      end

      // Contact outputs: freeze captures the present driven state
      for (int i = 0; i < NUM_OUT; i++) begin
         code = s_next.out_force[2*i +: 2];
         if (code == OUT_FREEZE && s_reg.out_force[2*i +: 2] != OUT_FREEZE) begin
            s_next.frozen[i] = s_reg.cout[i];
         end
         case (code)
            OUT_ENERGIZED: s_next.cout[i] = 1'b1;
            OUT_DEENERGIZED: s_next.cout[i] = 1'b0;
            OUT_FREEZE: s_next.cout[i] = s_next.frozen[i];
            default: s_next.cout[i] = contact_drive_in[i];
         endcase
      end

      // Channel testers, one per channel with its own state
      for (int c = 0; c < NCH; c++) begin
         s_next.tx[c] = 1'b0;
         if (!active || !s_next.orig[c]) begin
            s_next.st[c] = CH_IDLE;
            s_next.cnt[c] = 32'h0000_0000;
            if (!(active && s_next.rep[c])) begin
               s_next.res[c] = RES_NOT_ACTIVE;
            end
            // Repeat end returns the received signal one cycle later
            if (active && s_next.rep[c]) begin
               s_next.tx[c] = ch_test_rx_in[c];
            end
         end else begin
            case (s_reg.st[c])
               CH_IDLE: begin
                  s_next.st[c] = CH_SEND;
                  s_next.cnt[c] = 32'h0000_0000;
               end
               CH_SEND: begin
                  s_next.tx[c] = 1'b1;
                  s_next.st[c] = CH_WAIT;
                  s_next.cnt[c] = 32'h0000_0000;
               end
               CH_WAIT: begin
                  s_next.cnt[c] = s_reg.cnt[c] + 32'h0000_0001;
                  if (ch_test_rx_in[c]) begin
                     s_next.delay[c] = s_reg.cnt[c] + 32'h0000_0001;
                     s_next.res[c] = RES_OK;
                     s_next.st[c] = CH_HOLD;
                  end else if (s_reg.cnt[c] == REPLY_LAST) begin
                     s_next.res[c] = RES_FAIL;
                     s_next.st[c] = CH_HOLD;
                  end
               end
               CH_HOLD: begin
                  s_next.cnt[c] = s_reg.cnt[c] + 32'h0000_0001;
                  if (s_reg.cnt[c] >= PERIOD_LAST) begin
                     s_next.st[c] = CH_SEND;
                  end
               end
               default: s_next.st[c] = CH_IDLE;
            endcase
         end
      end

      // Readies registered so every port leaves a flip-flop; low while a transfer is held
      s_next.awrdy = !s_next.aw_held && !s_next.bvalid;
      s_next.wrdy = !s_next.w_held && !s_next.bvalid;
      s_next.arrdy = !s_next.rvalid;
   end

   // State register with synchronous reset
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready_out = s_reg.awrdy;
   assign s_axi_wready_out = s_reg.wrdy;
   assign s_axi_bvalid_out = s_reg.bvalid;
   assign s_axi_bresp_out = s_reg.bresp;
   assign s_axi_arready_out = s_reg.arrdy;
   assign s_axi_rvalid_out = s_reg.rvalid;
   assign s_axi_rdata_out = s_reg.rdata;
   assign s_axi_rresp_out = s_reg.rresp;
   assign contact_in_out = s_reg.cin;
   assign contact_out_out = s_reg.cout;
   assign test_led_out = s_reg.led;
   assign ch_test_tx_out = s_reg.tx;
endmodule // test_mode_channel_tester

//--- sim/remote_repeater_model.sv
module remote_repeater_model (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic [1:0] tx_in,
   input wire logic [1:0] echo_en_in,
   input wire logic [1:0] ping_in,
   input wire logic [3:0] delay_in,
   output logic [1:0] rx_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] line0_reg;
   logic [15:0] line1_reg;
   // Transit path of each channel, one stage per cycle; all delay sits on the outgoing side, the return and pings are undelayed
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         line0_reg <= 16'h0000;
         line1_reg <= 16'h0000;
      end else begin
         line0_reg <= {line0_reg[14:0], tx_in[0]};
         line1_reg <= {line1_reg[14:0], tx_in[1]};
      end
   end
   // Repeat end returns what it got after the set delay; as originator it sends its own pings
   assign rx_out[0] = echo_en_in[0] ? line0_reg[delay_in - 4'h1] : ping_in[0];
   assign rx_out[1] = echo_en_in[1] ? line1_reg[delay_in - 4'h1] : ping_in[1];
endmodule // remote_repeater_model

//--- sim/test_mode_channel_tester_assertions.sv
module test_mode_channel_tester_assertions
   import test_mode_pkg::*;
#(
   parameter int NUM_IN = 8,
   parameter int NUM_OUT = 8,
   parameter longint TIMEOUT_CYCLES = TEST_TIMEOUT_CYCLES
) (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [31:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0] s_axi_rresp_out,
   input wire logic s_axi_rvalid_out,
   input wire logic [NUM_IN-1:0] contact_sense_in,
   input wire logic [NUM_OUT-1:0] contact_drive_in,
   input wire logic [NUM_IN-1:0] contact_in_out,
   input wire logic [NUM_OUT-1:0] contact_out_out,
   input wire logic test_led_out,
   input wire logic [1:0] ch_test_tx_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] idle_cnt_reg;
   // Cycles since the last accepted write address, saturating
   always_ff @(posedge clock_in) begin
      if (!rst_b_in || (s_axi_awvalid_in && s_axi_awready_out)) begin
         idle_cnt_reg <= 32'h0000_0000;
      end else if (idle_cnt_reg != 32'hFFFF_FFFF) begin
         idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   property p_in_normal; !test_led_out && $past(rst_b_in) |-> contact_in_out == $past(contact_sense_in); endproperty
   a_in_normal: assert property (p_in_normal)
      else $error("contact inputs not following sensed values outside test");
   property p_out_normal; !test_led_out && $past(rst_b_in) |-> contact_out_out == $past(contact_drive_in); endproperty
   a_out_normal: assert property (p_out_normal)
      else $error("contact outputs not following drive outside test");
   property p_quiet_off; (!test_led_out)[*2] |-> ch_test_tx_out == 2'h0; endproperty
   a_quiet_off: assert property (p_quiet_off)
      else $error("channel transmits with test mode off");
   property p_timeout_quiet; 64'(idle_cnt_reg) > TIMEOUT_CYCLES + 64'd40 |-> ch_test_tx_out == 2'h0; endproperty
   a_timeout_quiet: assert property (p_timeout_quiet)
      else $error("channel still transmits after the test timer ran out");
   property p_write_lat; s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out; endproperty
   a_write_lat: assert property (p_write_lat)
      else $error("write response not two cycles after address and data");
   property p_bvalid_hold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
   a_bvalid_hold: assert property (p_bvalid_hold)
      else $error("write response dropped before taken");
   property p_read_lat; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
   a_read_lat: assert property (p_read_lat)
      else $error("read data not one cycle after address");
   property p_unmapped_rd; s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in > 32'h0000_001C
      |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 32'h0000_0000; endproperty
   a_unmapped_rd: assert property (p_unmapped_rd)
      else $error("unmapped read not refused");
   c_tx: cover property (ch_test_tx_out[0]);
   c_led_fall: cover property ($fell(test_led_out));
   c_slverr: cover property (s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
endmodule // test_mode_channel_tester_assertions
bind test_mode_channel_tester test_mode_channel_tester_assertions #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT),
   .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.*);

//--- sim/tb_top.sv
module tb_top;
   import test_mode_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {string name; bit is_read; logic [31:0] data; logic [1:0] resp;} exp_s;
   exp_s exp_q[$];
   exp_s e;
   int err_count = 0, tests_run = 0, seed = 75;
   logic clock_in = 1'b0, rst_b_in = 1'b0, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out, test_led_out;
   logic [31:0] s_axi_awaddr_in = '0, s_axi_wdata_in = '0, s_axi_araddr_in = '0, s_axi_rdata_out;
   logic [3:0] s_axi_wstrb_in = 4'hF, dly = 4'h3;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, ch_test_rx_in, ch_test_tx_out, echo_en = '0, ping = '0;
   logic [7:0] contact_sense_in = '0, contact_drive_in = '0, contact_in_out, contact_out_out, exp_in, exp_out, frz;
   logic [15:0] codes;
   // Free-running 100 MHz clock
   always #5 clock_in = ~clock_in;
   test_mode_channel_tester #(.TIMEOUT_CYCLES(200), .REPLY_CYCLES(20), .PERIOD_CYCLES(50)) u_dut (.*);
   remote_repeater_model u_far (.clock_in(clock_in), .rst_b_in(rst_b_in), .tx_in(ch_test_tx_out),
      .echo_en_in(echo_en), .ping_in(ping), .delay_in(dly), .rx_out(ch_test_rx_in));
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (exp !== got) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   // Bus write: address and data offered together, each released once taken
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      exp_q.push_back('{"write", 1'b0, 32'h0, r});
      @(posedge clock_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      do begin
         @(posedge clock_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (!s_axi_bvalid_out);
      s_axi_bready_in <= 1'b0;
      repeat (2) @(posedge clock_in);
   endtask
   task automatic rd(input string n, input logic [31:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      exp_q.push_back('{n, 1'b1, d, r});
      @(posedge clock_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do begin
         @(posedge clock_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (!s_axi_rvalid_out);
      s_axi_rready_in <= 1'b0;
   endtask
   // Response watcher: oldest note against each answer
   always @(posedge clock_in) begin
      if ((s_axi_bvalid_out && s_axi_bready_in) || (s_axi_rvalid_out && s_axi_rready_in)) begin
         e = exp_q.pop_front();
         if (e.is_read) check(e.name, e.data, s_axi_rdata_out);
         check({e.name, " resp"}, 32'(e.resp), e.is_read ? 32'(s_axi_rresp_out) : 32'(s_axi_bresp_out));
      end
   end
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clock_in);
      err_count++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge clock_in);
      rst_b_in <= 1'b1;
      contact_sense_in <= 8'($random(seed));
      contact_drive_in <= 8'($random(seed));
      rd("ctrl", CTRL_OFS, 32'h0);
      rd("status", STATUS_OFS, 32'h0);
      rd("unmapped", 32'h0000_0020, 32'h0, RESP_SLVERR);
      wr(32'h0000_0040, 32'h0000_0001, RESP_SLVERR);
      rd("io", IO_STATE_OFS, {8'h00, contact_drive_in, 8'h00, contact_sense_in});
      // Inputs forced open, closed, left alone, and the spare code
      codes = 16'hC000;
      for (int i = 0; i < 7; i++) codes[2*i +: 2] = 2'(i % 3);
      for (int i = 0; i < 8; i++) exp_in[i] = codes[2*i +: 2] == IN_OPEN ? 1'b0 :
         codes[2*i +: 2] == IN_CLOSED ? 1'b1 : contact_sense_in[i];
      wr(IN_FORCE_OFS, {16'h0000, codes});
      rd("in forced", IO_STATE_OFS, {8'h00, contact_drive_in, 8'h00, exp_in});
      rd("led on", STATUS_OFS, 32'h1);
      wr(IN_FORCE_OFS, 32'h0);
      rd("in normal", IO_STATE_OFS, {8'h00, contact_drive_in, 8'h00, contact_sense_in});
      // Every output code, then the drive turns over under freeze
      frz = contact_drive_in;
      wr(OUT_FORCE_OFS, 32'h0000_E4E4);
      contact_drive_in <= ~frz;
      for (int i = 0; i < 8; i++) exp_out[i] = i % 4 == 1 ? 1'b1 : i % 4 == 2 ? 1'b0 : i % 4 == 3 ? frz[i] : ~frz[i];
      repeat (2) @(posedge clock_in);
      rd("out forced", IO_STATE_OFS, {8'h00, exp_out, 8'h00, contact_sense_in});
      rd("led out", STATUS_OFS, 32'h1);
      wr(OUT_FORCE_OFS, 32'h0);
      rd("out normal", IO_STATE_OFS, {8'h00, ~frz, 8'h00, contact_sense_in});
      rd("led off", STATUS_OFS, 32'h0);
      // Channel 1 originates against a prompt far end, channel 2 repeats
      echo_en <= 2'b01;
      wr(CTRL_OFS, 32'h0000_0013);
      repeat (10) @(posedge clock_in);
      // Reported delay is the far end's latency plus the edge that samples the reply
      rd("status ok", STATUS_OFS, 32'h0000_0023);
      rd("delay 1", CH1_DELAY_OFS, 32'h4);
      rd("delay 2", CH2_DELAY_OFS, 32'h0);
      ping <= 2'b10;
      @(posedge clock_in);
      ping <= 2'b00;
      @(negedge clock_in);
      check("echo", 32'h1, 32'(ch_test_tx_out[1]));
      @(negedge clock_in);
      check("echo end", 32'h0, 32'(ch_test_tx_out[1]));
      @(posedge clock_in);
      // Far end falls silent, later attempts run out of reply time
      echo_en <= 2'b00;
      repeat (100) @(posedge clock_in);
      rd("status fail", STATUS_OFS, 32'h0000_0025);
      rd("delay kept", CH1_DELAY_OFS, 32'h4);
      // Roles swapped with a slow far end; a newly set bit restarts the timer
      echo_en <= 2'b10;
      dly <= 4'hB;
      wr(CTRL_OFS, 32'h0000_000D);
      repeat (20) @(posedge clock_in);
      rd("delay 2 slow", CH2_DELAY_OFS, 32'hC);
      rd("delay 1 own", CH1_DELAY_OFS, 32'h4);
      repeat (120) @(posedge clock_in);
      wr(CTRL_OFS, 32'h0000_000F);
      repeat (120) @(posedge clock_in);
      rd("restarted", CTRL_OFS, 32'hF);
      repeat (120) @(posedge clock_in);
      rd("expired", CTRL_OFS, 32'h1);
      rd("status cleared", STATUS_OFS, 32'h1);
      // Test mode left; the recorded delays stay readable for loading
      wr(CTRL_OFS, 32'h0);
      rd("led after test", STATUS_OFS, 32'h0);
      rd("delay 2 recorded", CH2_DELAY_OFS, 32'hC);
      rd("delay 1 recorded", CH1_DELAY_OFS, 32'h4);
      conclude();
   end
endmodule // tb_top
